// ---- mds_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH
// Register offsets (8-bit register port)
`define MDS_ADDR_FAULT_STATUS 8'h10
`define MDS_ADDR_FAULT_CAUSE 8'h00
`define MDS_ADDR_SPEED_LO 8'h01
`define MDS_ADDR_SPEED_HI 8'h02
`define MDS_ADDR_DEV_CTRL 8'h03
`define MDS_ADDR_NV_CTRL 8'h04
`define MDS_ADDR_PARAM_LO 8'h20
`define MDS_ADDR_PARAM_HI 8'h2B
// Status bit positions
`define MDS_BIT_OVER_TEMP 7
`define MDS_BIT_LOW_POWER 6
`define MDS_BIT_OVER_CURR 5
`define MDS_BIT_ROTOR_BLK 4
// Control bit positions
`define MDS_BIT_LP_INHIBIT 7
`define MDS_BIT_LOAD_SEL 6
`define MDS_BIT_WRITE_GO 0
// Key values and reset values
`define MDS_UNLOCK_KEY 8'hB6
`define MDS_RST_BYTE 8'h00
// Fault cause codes
`define MDS_CAUSE_NONE 8'h00
`define MDS_CAUSE_LOCK 8'h01
// Times in native units and cycle counts at 125 MHz
`define MDS_CLK_MHZ 125
`define MDS_T_ENTER_MS 5
`define MDS_T_EXIT_PIN_US 1
`define MDS_T_EXIT_SB_MS 700
`define MDS_T_LOCK_OFF_MS 5000
`define MDS_T_PROG_MS 24
`define MDS_CYC_ENTER (`MDS_T_ENTER_MS * 1000 * `MDS_CLK_MHZ)
`define MDS_CYC_EXIT_PIN (`MDS_T_EXIT_PIN_US * `MDS_CLK_MHZ)
`define MDS_CYC_EXIT_SB (`MDS_T_EXIT_SB_MS * 1000 * `MDS_CLK_MHZ)
`define MDS_CYC_LOCK_OFF (64'd`MDS_T_LOCK_OFF_MS * 64'd1000 * 64'd125)
`define MDS_CYC_PROG (`MDS_T_PROG_MS * 1000 * `MDS_CLK_MHZ)
`endif

// ---- mds_pkg.sv ----
// Types shared by the motor driver supervisor
package mds_pkg;
    typedef enum logic [1:0] {
        MDS_SRC_ANALOG,
        MDS_SRC_PWM,
        MDS_SRC_DIGITAL,
        MDS_SRC_RSVD
    } mds_src_t;
    typedef enum {
        MDS_RUN,
        MDS_LOW_POWER
    } mds_pwr_t;
    typedef enum {
        MDS_NV_IDLE,
        MDS_NV_BUSY
    } mds_nv_t;
endpackage

// ---- mds_hold_timer.sv ----
// Counts how long a qualifying condition has held without a break
`timescale 1ns/1ns
module mds_hold_timer
    import mds_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Condition and target
    input wire logic cond,
    input wire logic [WIDTH-1:0] limit,
    // Result
    output logic done
);
    logic [WIDTH-1:0] cnt_q;

    // Count while the condition holds, restart on any break
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else if (!cond)
            cnt_q <= '0;
        else if (cnt_q != limit)
            cnt_q <= cnt_q + 1'b1;
    end

    assign done = cond && (cnt_q == limit);
endmodule // mds_hold_timer

// ---- mds_supervisor.sv ----
// Supervisory control of a sensorless three-phase motor driver
// Function
// - Over-temperature stops drive, flag bit seven
// - Undervoltage locks out drive and register writes
// - Overcurrent tristates outputs, flag bit five
// - Rotor lock stops drive immediately
// - Resume after release interval, repeat if locked
// - Lock sets bit four and fault cause
// - Speed command from one of three sources
// - Peak duty from command, may be reduced
// - One phase grounded, two phases modulated
// - Amplitude scales linearly with peak duty
// - Low power entry stops the drive
// - Sleep disables regulator, bus, volatile registers except source select and inhibit
// - Standby keeps regulator, registers and bus
// - Inhibit blocks entry, never forces exit
// - Low-power flag at status bit six
// - Analog mode thresholds, standby exit higher
// - PWM mode pin low enter, high exit
// - Digital mode zero enters, nonzero exits standby
// - Write-go clears itself after programming
// - PWM enter time five milliseconds
// - PWM exit time one microsecond
// - Analog standby exit seven hundred milliseconds
`timescale 1ns/1ns
`include "mds_defs.svh"
module mds_supervisor
    import mds_pkg::*;
#(
    parameter int SLEEP_VARIANT = 0,
    parameter int ANA_W = 10,
    parameter logic [9:0] ANA_ENTER = 10'h0_009,
    parameter logic [9:0] ANA_EXIT_SB = 10'h0_025,
    parameter int ENTER_CYC = `MDS_CYC_ENTER,
    parameter int EXIT_SB_CYC = `MDS_CYC_EXIT_SB,
    parameter longint LOCK_OFF_CYC = `MDS_CYC_LOCK_OFF,
    parameter int PROG_CYC = `MDS_CYC_PROG
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Protection indications
    input wire logic over_temp_in,
    input wire logic undervoltage_in,
    input wire logic over_curr_in,
    input wire logic lock_detect_in,
    // Speed inputs
    input wire logic speed_pin,
    input wire logic [9:0] speed_level,
    input wire logic [9:0] speed_pwm_duty,
    input wire logic [9:0] duty_limit,
    // Drive outputs
    output logic [9:0] output_duty_peak,
    output logic [2:0] phase_pwm_en,
    output logic [2:0] phase_oe,
    output logic drive_active,
    // Power and storage control
    output logic regulator_en,
    output logic bus_en,
    output logic nv_program
);
    logic [7:0] fault_cause_register_q;
    logic [8:0] digital_speed_setting_q;
    logic [1:0] speed_source_select_q;
    logic low_power_inhibit_q;
    logic load_select_q;
    logic [7:0] program_unlock_key_q;
    logic nonvolatile_write_go_q;
    logic [7:0] param_q [12];
    logic rotor_blocked_flag;
    logic over_temperature_flag;
    logic over_current_flag;
    logic [63:0] lock_cnt_q;
    logic lock_hold_q;
    logic lock_retry_q;
    mds_pwr_t pwr_q;
    mds_nv_t nv_q;
    logic [31:0] nv_cnt_q;
    logic [1:0] phase_sel_q;
    logic [9:0] duty_q;
    logic sleep_wipe;
    logic enter_cond, exit_pin_cond, exit_sb_cond;
    logic enter_done, exit_pin_done, exit_sb_done;
    logic [31:0] exit_sb_lim;
    logic run_ok;
    logic [9:0] cmd;
    logic wr_en;

    // Temperature and current flags follow the indications directly; rotor flag also covers the lock hold
    assign over_temperature_flag = over_temp_in;
    assign over_current_flag = over_curr_in;
    assign rotor_blocked_flag = lock_detect_in | lock_hold_q;
    assign sleep_wipe = (SLEEP_VARIANT != 0) && (pwr_q == MDS_LOW_POWER);
    // Writes refused in sleep or lockout
    assign wr_en = reg_wr && bus_en && !undervoltage_in;

    // Host-written control registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            digital_speed_setting_q <= '0;
            speed_source_select_q <= '0;
            low_power_inhibit_q <= 1'b0;
            load_select_q <= 1'b0;
            program_unlock_key_q <= `MDS_RST_BYTE;
        end
        else if (sleep_wipe)
        begin
            digital_speed_setting_q <= '0;
            load_select_q <= 1'b0;
            program_unlock_key_q <= `MDS_RST_BYTE;
        end
        else if (wr_en)
        begin
            unique case (reg_addr)
                `MDS_ADDR_SPEED_LO:
                    digital_speed_setting_q[7:0] <= reg_wdata;
                `MDS_ADDR_SPEED_HI:
                begin
                    digital_speed_setting_q[8] <= reg_wdata[0];
                    speed_source_select_q <= reg_wdata[2:1];
                end
                `MDS_ADDR_DEV_CTRL:
                    program_unlock_key_q <= reg_wdata;
                `MDS_ADDR_NV_CTRL:
                begin
                    low_power_inhibit_q <= reg_wdata[`MDS_BIT_LP_INHIBIT];
                    load_select_q <= reg_wdata[`MDS_BIT_LOAD_SEL];
                end
                default:
                    ;
            endcase
        end
    end

    // Parameter registers, retained as they are backed by storage
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 12; i++)
                param_q[i] <= `MDS_RST_BYTE;
        end
        else if (wr_en && reg_addr >= `MDS_ADDR_PARAM_LO
                 && reg_addr <= `MDS_ADDR_PARAM_HI)
            param_q[4'(reg_addr - `MDS_ADDR_PARAM_LO)] <= reg_wdata;
    end

    // Programming sequence: go only with load select and key
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            nv_q <= MDS_NV_IDLE;
            nv_cnt_q <= '0;
            nonvolatile_write_go_q <= 1'b0;
        end
        else
        begin
            unique case (nv_q)
                MDS_NV_IDLE:
                    if (wr_en && reg_addr == `MDS_ADDR_NV_CTRL
                        && reg_wdata[`MDS_BIT_WRITE_GO] && load_select_q
                        && program_unlock_key_q == `MDS_UNLOCK_KEY)
                    begin
                        nv_q <= MDS_NV_BUSY;
                        nv_cnt_q <= '0;
                        nonvolatile_write_go_q <= 1'b1;
                    end
                MDS_NV_BUSY:
                    if (nv_cnt_q == 32'(PROG_CYC - 1))
                    begin
                        nv_q <= MDS_NV_IDLE;
                        nonvolatile_write_go_q <= 1'b0;
                    end
                    else
                        nv_cnt_q <= nv_cnt_q + 1'b1;
            endcase
        end
    end
    assign nv_program = nonvolatile_write_go_q;

    // Lock protection: stop at once, hold, retry
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lock_hold_q <= 1'b0;
            lock_cnt_q <= '0;
        end
        else if (!lock_hold_q)
        begin
            if (lock_detect_in)
            begin
                lock_hold_q <= 1'b1;
                lock_cnt_q <= '0;
            end
        end
        else if (lock_cnt_q == 64'(LOCK_OFF_CYC - 1))
            lock_hold_q <= 1'b0;
        else
            lock_cnt_q <= lock_cnt_q + 1'b1;
    end

    // One cycle of drive after a release retries a lasting lock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            lock_retry_q <= 1'b0;
        else
            lock_retry_q <= lock_hold_q && lock_detect_in
                            && lock_cnt_q == 64'(LOCK_OFF_CYC - 1);
    end

    // Cause kept for diagnosis, cleared in sleep
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            fault_cause_register_q <= `MDS_CAUSE_NONE;
        else if (lock_detect_in)
            fault_cause_register_q <= `MDS_CAUSE_LOCK;
        else if (sleep_wipe)
            fault_cause_register_q <= `MDS_CAUSE_NONE;
    end

    // Low-power conditions per speed source
    always_comb
    begin
        enter_cond = 1'b0;
        exit_sb_cond = speed_pin;
        exit_sb_lim = 32'(`MDS_CYC_EXIT_PIN);
        unique case (mds_src_t'(speed_source_select_q))
            MDS_SRC_ANALOG:
            begin
                enter_cond = speed_level < ANA_ENTER;
                exit_sb_cond = speed_level > ANA_EXIT_SB;
                exit_sb_lim = 32'(EXIT_SB_CYC);
            end
            MDS_SRC_PWM:
                enter_cond = !speed_pin;
            MDS_SRC_DIGITAL:
            begin
                enter_cond = digital_speed_setting_q == 9'h0_00;
                exit_sb_cond = digital_speed_setting_q != 9'h0_00;
            end
            default:
                ;
        endcase
    end
    assign exit_pin_cond = speed_pin && (pwr_q == MDS_LOW_POWER);

    // Duration timers restart on interruption
    mds_hold_timer #(.WIDTH(32)) u_enter (
        .clock(clock),
        .rst(rst),
        .cond(enter_cond && pwr_q == MDS_RUN && !low_power_inhibit_q),
        .limit(32'(ENTER_CYC - 1)),
        .done(enter_done)
    );
    mds_hold_timer #(.WIDTH(32)) u_exit_pin (
        .clock(clock),
        .rst(rst),
        .cond(exit_pin_cond),
        .limit(32'(`MDS_CYC_EXIT_PIN - 1)),
        .done(exit_pin_done)
    );
    mds_hold_timer #(.WIDTH(32)) u_exit_sb (
        .clock(clock),
        .rst(rst),
        .cond(exit_sb_cond && pwr_q == MDS_LOW_POWER),
        .limit(exit_sb_lim - 1'b1),
        .done(exit_sb_done)
    );

    // Low-power state; inhibit only blocks entry
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pwr_q <= MDS_RUN;
        else
        begin
            unique case (pwr_q)
                MDS_RUN:
                    if (enter_done)
                        pwr_q <= MDS_LOW_POWER;
                MDS_LOW_POWER:
                    if (SLEEP_VARIANT != 0 ? exit_pin_done
                        : exit_sb_done)
                        pwr_q <= MDS_RUN;
            endcase
        end
    end
    assign regulator_en = !sleep_wipe;
    assign bus_en = !sleep_wipe;

    // Drive is allowed only with no undervoltage, over-temperature, lock or low power
    assign run_ok = !undervoltage_in && !over_temp_in
                    && !lock_hold_q
                    && (!lock_detect_in || lock_retry_q)
                    && pwr_q == MDS_RUN;

    // Command source select and duty limiting
    always_comb
    begin
        unique case (mds_src_t'(speed_source_select_q))
            MDS_SRC_ANALOG: cmd = speed_level;
            MDS_SRC_PWM: cmd = speed_pwm_duty;
            MDS_SRC_DIGITAL: cmd = {digital_speed_setting_q, 1'b0};
            default: cmd = '0;
        endcase
    end

    // Peak duty register, the command clamped to the duty limit
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            duty_q <= '0;
        else if (!run_ok)
            duty_q <= '0;
        else
            duty_q <= (cmd > duty_limit) ? duty_limit : cmd;
    end
    assign output_duty_peak = duty_q;

    // Rotate the grounded phase around the three
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phase_sel_q <= '0;
        else if (run_ok)
            phase_sel_q <= (phase_sel_q == 2'd2) ? 2'd0 : phase_sel_q + 1'b1;
    end
    always_comb
    begin
        phase_pwm_en = 3'b111 & ~(3'b001 << phase_sel_q);
        if (!run_ok)
            phase_pwm_en = '0;
    end
    assign phase_oe = over_curr_in ? 3'b000 : 3'b111;
    assign drive_active = run_ok && !over_curr_in;

    // Register read data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (reg_rd && bus_en)
        begin
            reg_rdata <= '0;
            if (reg_addr == `MDS_ADDR_FAULT_STATUS)
            begin
                reg_rdata[`MDS_BIT_OVER_TEMP] <= over_temperature_flag;
                reg_rdata[`MDS_BIT_LOW_POWER] <= pwr_q == MDS_LOW_POWER;
                reg_rdata[`MDS_BIT_OVER_CURR] <= over_current_flag;
                reg_rdata[`MDS_BIT_ROTOR_BLK] <= rotor_blocked_flag;
            end
            else if (reg_addr == `MDS_ADDR_FAULT_CAUSE)
                reg_rdata <= fault_cause_register_q;
            else if (reg_addr == `MDS_ADDR_SPEED_LO)
                reg_rdata <= digital_speed_setting_q[7:0];
            else if (reg_addr == `MDS_ADDR_SPEED_HI)
                reg_rdata <= {5'h0_0, speed_source_select_q,
                              digital_speed_setting_q[8]};
            else if (reg_addr == `MDS_ADDR_NV_CTRL)
                reg_rdata <= {low_power_inhibit_q, load_select_q, 5'h0_0,
                              nonvolatile_write_go_q};
            else if (reg_addr >= `MDS_ADDR_PARAM_LO
                     && reg_addr <= `MDS_ADDR_PARAM_HI)
                reg_rdata <= param_q[4'(reg_addr - `MDS_ADDR_PARAM_LO)];
        end
    end

    // Checks
    a_over_temperature_flag_stop: assert property (@(posedge clock) disable iff (rst)
        over_temp_in |-> !drive_active && phase_pwm_en == 3'b000)
        else $error("drive active during over-temperature");
    a_uv_lockout: assert property (@(posedge clock) disable iff (rst)
        undervoltage_in |=> output_duty_peak == 10'h0_00)
        else $error("duty nonzero in undervoltage");
    a_oc_tristate: assert property (@(posedge clock) disable iff (rst)
        over_curr_in |-> phase_oe == 3'b000)
        else $error("outputs driven during overcurrent");
    a_lock_stop: assert property (@(posedge clock) disable iff (rst)
        $rose(lock_detect_in) |-> !drive_active ##1 lock_hold_q)
        else $error("lock did not stop drive");
    a_lock_cause: assert property (@(posedge clock) disable iff (rst)
        lock_detect_in |=> fault_cause_register_q == `MDS_CAUSE_LOCK)
        else $error("lock cause not recorded");
    a_phase_ground: assert property (@(posedge clock) disable iff (rst)
        run_ok |-> $countones(phase_pwm_en) == 2)
        else $error("not exactly two phases modulated");
    a_lp_stop: assert property (@(posedge clock) disable iff (rst)
        pwr_q == MDS_LOW_POWER |-> !drive_active)
        else $error("drive active in low power");
    a_inhibit_entry: assert property (@(posedge clock) disable iff (rst)
        pwr_q == MDS_RUN && low_power_inhibit_q |=> pwr_q == MDS_RUN)
        else $error("entered low power while inhibited");
    sequence s_go_start;
        nv_q == MDS_NV_IDLE ##1 nv_q == MDS_NV_BUSY;
    endsequence
    a_go_held: assert property (@(posedge clock) disable iff (rst)
        s_go_start |-> nonvolatile_write_go_q[*8])
        else $error("write go dropped early");
endmodule // mds_supervisor

// ---- mds_host_model.sv ----
// Host model: drives the register port and the speed pin
`timescale 1ns/1ns
`include "mds_defs.svh"
module mds_host_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Speed pin
    output logic speed_pin
);
    // Idle levels at time zero, pin high keeps the part awake
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        speed_pin = 1'b1;
    end

    // One write; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; data is taken once the registered answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // Speed pin level, changed on a rising edge
    task automatic pin(input logic v);
        @(posedge clock);
        speed_pin <= v;
    endtask

    // Storage programming: load select, parameters, key, then go
    task automatic program_nv(input logic [7:0] rm, input logic [7:0] kt);
        wr(`MDS_ADDR_NV_CTRL, 8'h40);
        wr(`MDS_ADDR_PARAM_LO, rm);
        wr(`MDS_ADDR_PARAM_LO + 8'h01, kt);
        for (int i = 2; i < 12; i++)
            wr(`MDS_ADDR_PARAM_LO + 8'(i), 8'(i));
        wr(`MDS_ADDR_DEV_CTRL, `MDS_UNLOCK_KEY);
        wr(`MDS_ADDR_NV_CTRL, 8'h41);
    endtask
endmodule // mds_host_model

// ---- motor_driver_supervisor_test.sv ----
// Self-checking testbench for the motor driver supervisor
`timescale 1ns/1ns
`include "mds_defs.svh"
module motor_driver_supervisor_test;
    localparam int EN = 20;
    localparam int EXS = 30;
    localparam int LOFF = 40;
    localparam int PRG = 50;
    localparam int EXP = 125;
    logic clock, rst, reg_wr, reg_rd, speed_pin, drive_active;
    logic over_temp_in, undervoltage_in, over_curr_in, lock_detect_in;
    logic regulator_en, bus_en, nv_program;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [9:0] speed_level, speed_pwm_duty, duty_limit, output_duty_peak;
    logic [2:0] phase_pwm_en, phase_oe;
    int error_cnt = 0;
    int samples_checked = 0;

    // Measured pin duty is the inverse of the analog level
    assign speed_pwm_duty = ~speed_level;

    mds_host_model host (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .speed_pin(speed_pin)
    );

    mds_supervisor #(
        .SLEEP_VARIANT(0), .ENTER_CYC(EN), .EXIT_SB_CYC(EXS),
        .LOCK_OFF_CYC(LOFF), .PROG_CYC(PRG)
    ) dut (
        .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .over_temp_in(over_temp_in), .undervoltage_in(undervoltage_in),
        .over_curr_in(over_curr_in), .lock_detect_in(lock_detect_in),
        .speed_pin(speed_pin), .speed_level(speed_level),
        .speed_pwm_duty(speed_pwm_duty), .duty_limit(duty_limit),
        .output_duty_peak(output_duty_peak), .phase_pwm_en(phase_pwm_en),
        .phase_oe(phase_oe), .drive_active(drive_active),
        .regulator_en(regulator_en), .bus_en(bus_en),
        .nv_program(nv_program)
    );

    // Free-running clock, 8 ns period
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Analog speed level, changed on a rising edge
    task automatic lvl(input logic [9:0] v);
        @(posedge clock);
        speed_level <= v;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_reg(input string what, input logic [7:0] a,
                           input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        check(what, d, e);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Idle reads, unmapped place, and the three speed sources
    task automatic t_sources();
        chk_reg("status", `MDS_ADDR_FAULT_STATUS, 8'h00);
        chk_reg("unmapped", 8'h55, 8'h00);
        lvl(10'h2AA);
        cyc(4);
        check("analog duty", output_duty_peak, 10'h2AA);
        check("phases", $countones(phase_pwm_en), 2);
        host.wr(`MDS_ADDR_SPEED_HI, 8'h02);
        cyc(4);
        check("pwm duty", output_duty_peak, 10'h155);
        host.wr(`MDS_ADDR_SPEED_LO, 8'h80);
        host.wr(`MDS_ADDR_SPEED_HI, 8'h05);
        cyc(4);
        check("digital duty", output_duty_peak, 10'h300);
        @(posedge clock);
        duty_limit <= 10'h100;
        cyc(4);
        check("limited duty", output_duty_peak, 10'h100);
        @(posedge clock);
        duty_limit <= 10'h3FF;
        $display("test sources done");
    endtask

    // Temperature, overcurrent and undervoltage
    task automatic t_protect();
        @(posedge clock);
        over_temp_in <= 1'b1;
        cyc(3);
        check("drive hot", drive_active, 1'b0);
        chk_reg("status hot", `MDS_ADDR_FAULT_STATUS, 8'h80);
        @(posedge clock);
        over_temp_in <= 1'b0;
        cyc(3);
        check("drive cool", drive_active, 1'b1);
        @(posedge clock);
        over_curr_in <= 1'b1;
        cyc(3);
        check("oe", phase_oe, 3'b000);
        chk_reg("status oc", `MDS_ADDR_FAULT_STATUS, 8'h20);
        @(posedge clock);
        over_curr_in <= 1'b0;
        cyc(3);
        check("drive oc gone", drive_active, 1'b1);
        @(posedge clock);
        undervoltage_in <= 1'b1;
        cyc(3);
        check("drive uv", drive_active, 1'b0);
        host.wr(`MDS_ADDR_SPEED_LO, 8'h10);
        @(posedge clock);
        undervoltage_in <= 1'b0;
        cyc(3);
        check("drive uv gone", drive_active, 1'b1);
        chk_reg("speed kept", `MDS_ADDR_SPEED_LO, 8'h80);
        $display("test protect done");
    endtask

    // Lock hold interval, flags, and repeated cycles
    task automatic t_lock();
        int hits;
        @(posedge clock);
        lock_detect_in <= 1'b1;
        cyc(1);
        check("drive locked", drive_active, 1'b0);
        chk_reg("status lock", `MDS_ADDR_FAULT_STATUS, 8'h10);
        chk_reg("cause", `MDS_ADDR_FAULT_CAUSE, `MDS_CAUSE_LOCK);
        @(posedge clock);
        lock_detect_in <= 1'b0;
        cyc(LOFF - 12);
        check("drive held", drive_active, 1'b0);
        cyc(12);
        check("drive resumed", drive_active, 1'b1);
        @(posedge clock);
        lock_detect_in <= 1'b1;
        hits = 0;
        repeat (LOFF + 12)
        begin
            @(posedge clock);
            #1;
            if (drive_active === 1'b1)
                hits++;
        end
        check("retry seen", hits > 0, 1'b1);
        check("relocked", drive_active, 1'b0);
        @(posedge clock);
        lock_detect_in <= 1'b0;
        cyc(2 * LOFF + 4);
        check("lock gone", drive_active, 1'b1);
        $display("test lock done");
    endtask

    // Pin-driven low power, restart of the count, inhibit
    task automatic t_lowpower();
        host.wr(`MDS_ADDR_SPEED_HI, 8'h02);
        host.pin(1'b0);
        cyc(EN - 4);
        host.pin(1'b1);
        host.pin(1'b0);
        cyc(EN - 4);
        check("count restarted", drive_active, 1'b1);
        cyc(8);
        check("drive lp", drive_active, 1'b0);
        chk_reg("status lp", `MDS_ADDR_FAULT_STATUS, 8'h40);
        check("regulator", {regulator_en, bus_en}, 2'b11);
        host.wr(8'h21, 8'h5A);
        chk_reg("standby reg", 8'h21, 8'h5A);
        host.wr(`MDS_ADDR_NV_CTRL, 8'h80);
        chk_reg("inhibit late", `MDS_ADDR_FAULT_STATUS, 8'h40);
        host.pin(1'b1);
        cyc(EXP - 8);
        check("exit early", drive_active, 1'b0);
        cyc(12);
        check("exit pin", drive_active, 1'b1);
        host.pin(1'b0);
        cyc(EN + 10);
        chk_reg("inhibited", `MDS_ADDR_FAULT_STATUS, 8'h00);
        host.wr(`MDS_ADDR_NV_CTRL, 8'h00);
        host.pin(1'b1);
        $display("test low power done");
    endtask

    // Digital and analog entry and exit conditions
    task automatic t_modes();
        host.wr(`MDS_ADDR_SPEED_LO, 8'h00);
        host.wr(`MDS_ADDR_SPEED_HI, 8'h04);
        cyc(EN + 6);
        chk_reg("digital lp", `MDS_ADDR_FAULT_STATUS, 8'h40);
        host.wr(`MDS_ADDR_SPEED_LO, 8'h20);
        cyc(EXP - 10);
        check("digital early", drive_active, 1'b0);
        cyc(16);
        chk_reg("digital out", `MDS_ADDR_FAULT_STATUS, 8'h00);
        lvl(10'h005);
        host.wr(`MDS_ADDR_SPEED_HI, 8'h00);
        cyc(EN + 6);
        chk_reg("analog lp", `MDS_ADDR_FAULT_STATUS, 8'h40);
        lvl(10'h010);
        cyc(EXS + 10);
        check("below exit", drive_active, 1'b0);
        lvl(10'h030);
        cyc(EXS - 6);
        check("analog early", drive_active, 1'b0);
        cyc(12);
        check("analog out", drive_active, 1'b1);
        $display("test modes done");
    endtask

    // Storage programming and self-clearing go bit
    task automatic t_program();
        host.program_nv(8'h3A, 8'h2D);
        cyc(1);
        check("programming", nv_program, 1'b1);
        chk_reg("go set", `MDS_ADDR_NV_CTRL, 8'h41);
        cyc(PRG);
        check("prog over", nv_program, 1'b0);
        chk_reg("go clear", `MDS_ADDR_NV_CTRL, 8'h40);
        chk_reg("param back", `MDS_ADDR_PARAM_LO, 8'h3A);
        $display("test program done");
    endtask

    // Main sequence: reset, then every scenario in turn
    initial
    begin
        rst = 1'b1;
        over_temp_in = 1'b0;
        undervoltage_in = 1'b0;
        over_curr_in = 1'b0;
        lock_detect_in = 1'b0;
        speed_level = 10'h3FF;
        duty_limit = 10'h3FF;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_sources();
        t_protect();
        t_lock();
        t_lowpower();
        t_modes();
        t_program();
        close_out();
    end

    // Watchdog against a hang
    initial
    begin
        #(8 * 6000);
        error_cnt++;
        close_out();
    end
endmodule // motor_driver_supervisor_test
